// ===== design/pds_phy.sv
/*
 * Physical layer end of the data service: free-running time counter,
 * timed transmit with result codes, receive delivery with preamble stamp.
 * Assumes the modulator and demodulator run on pclk and that the scheduler
 * flags forbidden slots and carrier on same-clock levels.
 */
`timescale 1ns/1ps
module pds_phy (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // service boundary
  pds_if.phy link,
  // line side transmit
  output logic line_on,
  output logic line_valid,
  output logic [7:0] line_byte,
  output logic [2:0] line_level,
  output logic [2:0] line_scheme,
  // scheduler levels
  input wire logic slot_forbidden,
  input wire logic carrier_busy,
  // demodulator side
  input wire logic dem_preamble,
  input wire logic dem_byte_valid,
  input wire logic [7:0] dem_byte,
  input wire logic dem_end,
  input wire logic dem_ok,
  input wire logic [15:0] dem_len,
  input wire logic [3:0] dem_level,
  input wire logic [2:0] dem_scheme
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    pds_pkg::pds_tx_state_type st;
    logic [11:0] pre;
    logic [19:0] now;
    logic [19:0] start;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [2:0] lvl;
    logic [2:0] sch;
    logic ready;
    logic done;
    logic [7:0] res;
    logic tmr_v;
    logic [19:0] tmr;
    logic [19:0] stamp;
    logic rx_bv;
    logic [7:0] rx_b;
    logic rx_ind;
    logic rx_abort;
    logic [15:0] rx_len;
    logic [3:0] rx_lvl;
    logic [2:0] rx_sch;
    logic [19:0] rx_time;
    logic ln_on;
    logic ln_v;
    logic [7:0] ln_b;
  } pds_phy_type;

  pds_phy_type s_q;
  pds_phy_type s_d;

  // shared by transmit and receive paths
  function automatic logic pds_scheme_ok(input logic [2:0] sch);
    pds_scheme_ok = (sch != pds_pkg::SCHEME_UNUSED_A) &&
                    (sch != pds_pkg::SCHEME_UNUSED_B);
  endfunction : pds_scheme_ok

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [19:0] ahead;
    ahead = 20'h00000;
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.tmr_v = 1'b0;
    s_d.rx_bv = 1'b0;
    s_d.rx_ind = 1'b0;
    s_d.rx_abort = 1'b0;
    s_d.ln_v = 1'b0;

    if (s_q.pre == pds_pkg::TICK_LAST) begin
      s_d.pre = 12'h000;
      s_d.now = s_q.now + 20'h00001;
    end else begin
      s_d.pre = s_q.pre + 12'h001;
    end
    // counter has no stop or load path

    if (link.tmr_query) begin
      s_d.tmr_v = 1'b1;
      s_d.tmr = s_q.now;
    end

    case (s_q.st)
      pds_pkg::PDS_IDLE: begin
        if (link.tx_req) begin
          s_d.len = link.tx_len;
          s_d.lvl = link.tx_level;
          s_d.sch = link.tx_scheme;
          s_d.start = link.tx_time;
          s_d.cnt = 16'h0000;
          ahead = link.tx_time - s_q.now;
          s_d.done = 1'b1;
          if (link.tx_len == 16'h0000 || link.tx_len > pds_pkg::LEN_MAX) begin
            s_d.res = pds_pkg::RES_BAD_LENGTH;
          end else if (!pds_scheme_ok(link.tx_scheme)) begin
            s_d.res = pds_pkg::RES_BAD_SCHEME;
          end else if (ahead > pds_pkg::LATE_HORIZON) begin
            s_d.res = pds_pkg::RES_TOO_LATE;
          end else begin
            s_d.done = 1'b0;
            s_d.st = pds_pkg::PDS_WAIT;
          end
        end
      end
      pds_pkg::PDS_WAIT: begin
        if (s_q.now == s_q.start) begin
          if (slot_forbidden) begin
            s_d.done = 1'b1;
            s_d.res = pds_pkg::RES_FORBIDDEN;
            s_d.st = pds_pkg::PDS_IDLE;
          end else if (carrier_busy) begin
            s_d.done = 1'b1;
            s_d.res = pds_pkg::RES_BUSY;
            s_d.st = pds_pkg::PDS_IDLE;
          end else begin
            s_d.ready = 1'b1;
            s_d.ln_on = 1'b1;
            s_d.st = pds_pkg::PDS_SEND;
          end
        end
      end
      pds_pkg::PDS_SEND: begin
        if (slot_forbidden) begin
          s_d.res = pds_pkg::RES_FORBIDDEN;
          s_d.done = 1'b1;
        end else if (!link.tx_byte_valid) begin
          // frame bytes must keep pace with the line
          s_d.res = pds_pkg::RES_OVERRUN;
          s_d.done = 1'b1;
        end else begin
          // bytes pass as aligned octets, pad bits included
          s_d.ln_v = 1'b1;
          s_d.ln_b = link.tx_byte;
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.cnt + 16'h0001 == s_q.len) begin
            s_d.res = pds_pkg::RES_SUCCESS;
            s_d.done = 1'b1;
          end
        end
        if (s_d.done) begin
          s_d.ready = 1'b0;
          s_d.ln_on = 1'b0;
          s_d.st = pds_pkg::PDS_IDLE;
        end
      end
      default: begin
        s_d.st = pds_pkg::PDS_IDLE;
        s_d.ready = 1'b0;
        s_d.ln_on = 1'b0;
      end
    endcase

    if (dem_preamble) begin
      s_d.stamp = s_q.now;
    end
    // payload forwarded as it arrives, indication marks it valid
    if (dem_byte_valid) begin
      s_d.rx_bv = 1'b1;
      s_d.rx_b = dem_byte;
    end
    if (dem_end) begin
      // bad scheme means not a valid frame
      if (dem_ok && pds_scheme_ok(dem_scheme)) begin
        s_d.rx_ind = 1'b1;
        s_d.rx_len = dem_len;
        // level code passed as four bits
        s_d.rx_lvl = dem_level;
        s_d.rx_sch = dem_scheme;
        s_d.rx_time = s_q.stamp;
      end else begin
        s_d.rx_abort = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= pds_pkg::PDS_IDLE;
      s_q.now <= pds_pkg::TIME_RESET;
      s_q.lvl <= pds_pkg::LEVEL_MAX;
      s_q.res <= pds_pkg::RES_SUCCESS;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign link.tx_byte_ready = s_q.ready;
  assign link.tx_done = s_q.done;
  assign link.tx_result = s_q.res;
  assign link.tmr_valid = s_q.tmr_v;
  assign link.tmr_value = s_q.tmr;
  assign link.rx_byte_valid = s_q.rx_bv;
  assign link.rx_byte = s_q.rx_b;
  assign link.rx_ind = s_q.rx_ind;
  assign link.rx_abort = s_q.rx_abort;
  assign link.rx_len = s_q.rx_len;
  assign link.rx_level = s_q.rx_lvl;
  assign link.rx_scheme = s_q.rx_sch;
  assign link.rx_time = s_q.rx_time;
  assign line_on = s_q.ln_on;
  assign line_valid = s_q.ln_v;
  assign line_byte = s_q.ln_b;
  assign line_level = s_q.lvl;
  assign line_scheme = s_q.sch;
endmodule : pds_phy

// ===== design/pds_pkg.sv
/*
 * Shared constants and types for the powerline physical layer data service:
 * timer figures, code tables, result codes and the controller register map.
 * Assumes a single 250 MHz clock shared by both ends of the service boundary.
 */
package pds_pkg;
  // --------------------------------------------------------------------
  // time base
  // --------------------------------------------------------------------
  localparam int TICK_US = 10;
  localparam int CLK_MHZ = 250;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
  localparam int TIME_W = 20;
  localparam logic [19:0] TIME_RESET = 20'h00000;
  // start instants further ahead than this count as already passed
  localparam logic [19:0] LATE_HORIZON = 20'h80000;

  // --------------------------------------------------------------------
  // codes
  // --------------------------------------------------------------------
  localparam logic [2:0] SCHEME_UNUSED_A = 3'h3;
  localparam logic [2:0] SCHEME_UNUSED_B = 3'h7;
  localparam logic [2:0] LEVEL_MAX = 3'h0;
  localparam logic [15:0] LEN_MAX = 16'h0040;
  localparam logic [7:0] RES_SUCCESS = 8'h00;
  localparam logic [7:0] RES_TOO_LATE = 8'h01;
  localparam logic [7:0] RES_BAD_LENGTH = 8'h02;
  localparam logic [7:0] RES_BAD_SCHEME = 8'h03;
  localparam logic [7:0] RES_BAD_LEVEL = 8'h04;
  localparam logic [7:0] RES_OVERRUN = 8'h05;
  localparam logic [7:0] RES_BUSY = 8'h06;
  localparam logic [7:0] RES_FORBIDDEN = 8'h07;

  // --------------------------------------------------------------------
  // controller register map (byte addresses) and fields
  // --------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXCFG = 8'h04;
  localparam logic [7:0] REG_TXTIME = 8'h08;
  localparam logic [7:0] REG_TXDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_TIMER = 8'h14;
  localparam logic [7:0] REG_RXINFO = 8'h18;
  localparam logic [7:0] REG_RXTIME = 8'h1c;
  localparam logic [7:0] REG_RXDATA = 8'h20;
  localparam int CTRL_SEND = 0;
  localparam int CTRL_QUERY = 1;
  localparam int CTRL_CLEAR = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TIMER = 2;
  localparam int ST_RXOK = 3;
  localparam int ST_RXBAD = 4;
  localparam int BUF_DEPTH = 64;
  localparam logic [6:0] BUF_FULL = 7'h40;

  typedef enum logic [2:0] {
    PDS_IDLE = 3'b001,
    PDS_WAIT = 3'b010,
    PDS_SEND = 3'b100
  } pds_tx_state_type;
endpackage : pds_pkg

// ===== design/pds_if.sv
/*
 * Service boundary between the physical layer and its controller.
 * Assumes both parties run on the same pclk; no clocking block is used.
 */
`timescale 1ns/1ps
interface pds_if;
  // transmit request and its frame bytes
  logic tx_req;
  logic [15:0] tx_len;
  logic [2:0] tx_level;
  logic [2:0] tx_scheme;
  logic [19:0] tx_time;
  logic tx_byte_valid;
  logic [7:0] tx_byte;
  logic tx_byte_ready;
  // transmit result
  logic tx_done;
  logic [7:0] tx_result;
  // timer query
  logic tmr_query;
  logic tmr_valid;
  logic [19:0] tmr_value;
  // received payload and indication
  logic rx_byte_valid;
  logic [7:0] rx_byte;
  logic rx_ind;
  logic rx_abort;
  logic [15:0] rx_len;
  logic [3:0] rx_level;
  logic [2:0] rx_scheme;
  logic [19:0] rx_time;

  modport phy (
    input tx_req, tx_len, tx_level, tx_scheme, tx_time,
    input tx_byte_valid, tx_byte, tmr_query,
    output tx_byte_ready, tx_done, tx_result, tmr_valid, tmr_value,
    output rx_byte_valid, rx_byte, rx_ind, rx_abort,
    output rx_len, rx_level, rx_scheme, rx_time
  );
  modport mac (
    output tx_req, tx_len, tx_level, tx_scheme, tx_time,
    output tx_byte_valid, tx_byte, tmr_query,
    input tx_byte_ready, tx_done, tx_result, tmr_valid, tmr_value,
    input rx_byte_valid, rx_byte, rx_ind, rx_abort,
    input rx_len, rx_level, rx_scheme, rx_time
  );
endinterface : pds_if

// ===== design/pds_mac.sv
/*
 * Controller end of the data service: APB registers for software, a
 * transmit frame buffer, timer query and a receive payload buffer.
 * Assumes the physical layer end on the same pclk across pds_if.
 */
`timescale 1ns/1ps
module pds_mac (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // service boundary
  pds_if.mac link
);
  typedef struct packed {
    logic [pds_pkg::BUF_DEPTH-1:0][7:0] txb;
    logic [pds_pkg::BUF_DEPTH-1:0][7:0] rxb;
    logic [6:0] twp;
    logic [15:0] trp;
    logic [6:0] rwp;
    logic [6:0] rrp;
    logic [15:0] len;
    logic [2:0] lvl;
    logic [2:0] sch;
    logic [19:0] tm;
    logic req;
    logic bv;
    logic [7:0] bd;
    logic busy;
    logic [4:0] stk;
    logic [7:0] res;
    logic qry;
    logic [19:0] tmr;
    logic [15:0] rx_len;
    logic [3:0] rx_lvl;
    logic [2:0] rx_sch;
    logic [19:0] rx_time;
    logic rdy;
    logic err;
    logic [31:0] rd;
  } pds_mac_type;

  pds_mac_type s_q;
  pds_mac_type s_d;

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    logic wr;
    logic rd;
    logic hit;
    logic [15:0] nxt;
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.qry = 1'b0;
    wr = psel && penable && s_q.rdy && pwrite;
    rd = psel && penable && s_q.rdy && !pwrite;
    hit = 1'b1;
    nxt = s_q.trp + 16'h0001;

    // apb: answer in the first access cycle
    s_d.rdy = psel && !penable;
    if (psel && !penable) begin
      s_d.rd = 32'h00000000;
      case (paddr)
        pds_pkg::REG_CTRL: s_d.rd = 32'h00000000;
        pds_pkg::REG_TXCFG: s_d.rd = {9'h000, s_q.sch, 1'b0, s_q.lvl, s_q.len};
        pds_pkg::REG_TXTIME: s_d.rd = {12'h000, s_q.tm};
        pds_pkg::REG_TXDATA: s_d.rd = {25'h0000000, s_q.twp};
        pds_pkg::REG_STATUS: s_d.rd = {9'h000, s_q.rwp, s_q.res, 3'h0, s_q.stk};
        pds_pkg::REG_TIMER: s_d.rd = {12'h000, s_q.tmr};
        pds_pkg::REG_RXINFO: s_d.rd = {9'h000, s_q.rx_sch, s_q.rx_lvl, s_q.rx_len};
        pds_pkg::REG_RXTIME: s_d.rd = {12'h000, s_q.rx_time};
        pds_pkg::REG_RXDATA: s_d.rd = {24'h000000, s_q.rxb[s_q.rrp[5:0]]};
        default: hit = 1'b0;
      endcase
      s_d.err = !hit;
    end

    // software side effects at the completing edge
    if (wr) begin
      case (paddr)
        pds_pkg::REG_CTRL: begin
          // no new request while one is outstanding
          if (pwdata[pds_pkg::CTRL_SEND] && !s_q.busy) begin
            s_d.req = 1'b1;
            s_d.busy = 1'b1;
            s_d.trp = 16'h0000;
            s_d.bv = s_q.len != 16'h0000 && s_q.twp != 7'h00;
            s_d.bd = s_q.txb[0];
          end
          s_d.qry = pwdata[pds_pkg::CTRL_QUERY];
          if (pwdata[pds_pkg::CTRL_CLEAR] && !s_q.busy) begin
            s_d.twp = 7'h00;
          end
        end
        pds_pkg::REG_TXCFG: begin
          s_d.len = pwdata[15:0];
          s_d.lvl = pwdata[18:16];
          s_d.sch = pwdata[22:20];
        end
        pds_pkg::REG_TXTIME: s_d.tm = pwdata[19:0];
        pds_pkg::REG_TXDATA: begin
          // software loads aligned bytes, pad bits first
          if (s_q.twp != pds_pkg::BUF_FULL && !s_q.busy) begin
            s_d.txb[s_q.twp[5:0]] = pwdata[7:0];
            s_d.twp = s_q.twp + 7'h01;
          end
        end
        pds_pkg::REG_STATUS: s_d.stk = s_q.stk & ~pwdata[4:0];
        default: s_d.stk = s_q.stk;
      endcase
    end
    if (rd && paddr == pds_pkg::REG_RXDATA && s_q.rrp != s_q.rwp) begin
      s_d.rrp = s_q.rrp + 7'h01;
    end

    // frame bytes advance on each accepted byte
    if (s_q.bv && link.tx_byte_ready) begin
      s_d.trp = nxt;
      // stale slots past the load are never sent; a short load overruns
      s_d.bv = nxt < s_q.len && nxt < {9'h000, s_q.twp};
      s_d.bd = s_q.txb[nxt[5:0]];
    end
    // result ends the request; set wins over clear
    if (link.tx_done) begin
      s_d.busy = 1'b0;
      s_d.bv = 1'b0;
      s_d.res = link.tx_result;
      s_d.stk[pds_pkg::ST_DONE] = 1'b1;
    end
    s_d.stk[pds_pkg::ST_BUSY] = s_d.busy;
    if (link.tmr_valid) begin
      s_d.tmr = link.tmr_value;
      s_d.stk[pds_pkg::ST_TIMER] = 1'b1;
    end
    // receive payload, restarted after each aborted frame
    if (link.rx_byte_valid && s_q.rwp != pds_pkg::BUF_FULL) begin
      s_d.rxb[s_q.rwp[5:0]] = link.rx_byte;
      s_d.rwp = s_q.rwp + 7'h01;
    end
    if (link.rx_ind) begin
      s_d.rx_len = link.rx_len;
      s_d.rx_lvl = link.rx_level;
      s_d.rx_sch = link.rx_scheme;
      s_d.rx_time = link.rx_time;
      s_d.stk[pds_pkg::ST_RXOK] = 1'b1;
    end
    if (link.rx_abort) begin
      s_d.rwp = 7'h00;
      s_d.stk[pds_pkg::ST_RXBAD] = 1'b1;
    end
    if (link.rx_ind || link.rx_abort) begin
      s_d.rrp = 7'h00;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rd;
  assign pready = s_q.rdy;
  assign pslverr = s_q.err;
  assign link.tx_req = s_q.req;
  assign link.tx_len = s_q.len;
  assign link.tx_level = s_q.lvl;
  assign link.tx_scheme = s_q.sch;
  assign link.tx_time = s_q.tm;
  assign link.tx_byte_valid = s_q.bv;
  assign link.tx_byte = s_q.bd;
  assign link.tmr_query = s_q.qry;
endmodule : pds_mac

// ===== verif/pds_checker.sv
/*
 * Checker watching the data service boundary between both ends.
 * Assumes every signal on one pclk with presetn active low.
 */
`timescale 1ns/1ps
module pds_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // transmit side
  input wire logic tx_req,
  input wire logic [15:0] tx_len,
  input wire logic [2:0] tx_scheme,
  input wire logic tx_byte_valid,
  input wire logic tx_byte_ready,
  input wire logic tx_done,
  input wire logic [7:0] tx_result,
  // timer and receive side
  input wire logic tmr_query,
  input wire logic tmr_valid,
  input wire logic [19:0] tmr_value,
  input wire logic rx_ind,
  input wire logic rx_abort,
  input wire logic [2:0] rx_scheme
);
  logic [11:0] cnt_q;
  logic [19:0] ref_q;
  logic len_ok;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------------
  // reference time base
  // ------------------------------------------------------------------
  // phase may differ by a cycle from the device, so one tick of slack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 12'h000;
      ref_q <= 20'h00000;
    end else if (cnt_q == pds_pkg::TICK_LAST) begin
      cnt_q <= 12'h000;
      ref_q <= ref_q + 20'h00001;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end
  // length inside the accepted span
  assign len_ok = tx_len != 16'h0000 && tx_len <= pds_pkg::LEN_MAX;

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  // query answered
  chk_query_answer: assert property (tmr_query |=> tmr_valid)
    else $error("timer query unanswered");
  chk_timer_value: assert property (tmr_valid |->
    20'(ref_q - tmr_value + 20'h00001) <= 20'h00002)
    else $error("timer value off");
  chk_len_refuse: assert property (tx_req && !len_ok |=>
    tx_done && tx_result == pds_pkg::RES_BAD_LENGTH)
    else $error("bad length not refused");
  chk_scheme_refuse: assert property (tx_req && len_ok &&
    (tx_scheme == 3'h3 || tx_scheme == 3'h7) |=>
    tx_done && tx_result == pds_pkg::RES_BAD_SCHEME)
    else $error("unused scheme not refused");
  chk_ready_ends: assert property ($fell(tx_byte_ready) |-> tx_done)
    else $error("ready dropped without result");
  chk_done_single: assert property (tx_done |=> !tx_done [*3])
    else $error("result repeated");
  chk_overrun_code: assert property (tx_byte_ready && !tx_byte_valid
    |-> ##[1:2] tx_done && tx_result == pds_pkg::RES_OVERRUN)
    else $error("overrun not reported");
  chk_single_req: assert property (tx_req |-> !tx_byte_ready)
    else $error("request while sending");
  chk_rx_scheme: assert property (rx_ind |-> !rx_abort &&
    rx_scheme != 3'h3 && rx_scheme != 3'h7)
    else $error("bad received scheme delivered");
endmodule : pds_checker

// ===== verif/tb_top.sv
/*
 * Bench joining both ends of the data service, software side over APB.
 * Assumes the register map of pds_pkg and a 250 MHz pclk.
 */
`timescale 1ns/1ps
module tb_top;
  // ------------------------------------------------------------------
  // signals and ends
  // ------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic line_on, line_valid, slot_forbidden, carrier_busy;
  logic dem_preamble, dem_byte_valid, dem_end, dem_ok;
  logic [7:0] paddr, line_byte, dem_byte, line_idx, on_cnt;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] line_level, line_scheme, dem_scheme;
  logic [15:0] dem_len;
  logic [3:0] dem_level;
  logic [19:0] t1, t2;
  int num_errors = 0;
  int total_checks = 0;
  pds_if link ();

  pds_phy i_pds_phy (.pclk(pclk), .presetn(presetn), .link(link.phy),
    .line_on(line_on), .line_valid(line_valid), .line_byte(line_byte),
    .line_level(line_level), .line_scheme(line_scheme),
    .slot_forbidden(slot_forbidden), .carrier_busy(carrier_busy),
    .dem_preamble(dem_preamble), .dem_byte_valid(dem_byte_valid),
    .dem_byte(dem_byte), .dem_end(dem_end), .dem_ok(dem_ok),
    .dem_len(dem_len), .dem_level(dem_level), .dem_scheme(dem_scheme));
  pds_mac i_pds_mac (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.mac));
  pds_checker i_pds_checker (.pclk(pclk), .presetn(presetn),
    .tx_req(link.tx_req), .tx_len(link.tx_len),
    .tx_scheme(link.tx_scheme), .tx_byte_valid(link.tx_byte_valid),
    .tx_byte_ready(link.tx_byte_ready), .tx_done(link.tx_done),
    .tx_result(link.tx_result), .tmr_query(link.tmr_query),
    .tmr_valid(link.tmr_valid), .tmr_value(link.tmr_value),
    .rx_ind(link.rx_ind), .rx_abort(link.rx_abort),
    .rx_scheme(link.rx_scheme));

  // 4 ns period
  always #2 pclk = ~pclk;

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!w) rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // poll a sticky status bit, then clear it
  task automatic wait_st(input int b);
    int n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 3000) begin
      apb(1'b0, pds_pkg::REG_STATUS, 32'h0);
      n++;
    end
    check("status wait", {31'h0, rd[b]}, 32'h1);
    apb(1'b1, pds_pkg::REG_STATUS, 32'h1 << b);
  endtask : wait_st

  task automatic now_get(output logic [19:0] t);
    apb(1'b1, pds_pkg::REG_CTRL, 32'h1 << pds_pkg::CTRL_QUERY);
    wait_st(pds_pkg::ST_TIMER);
    apb(1'b0, pds_pkg::REG_TIMER, 32'h0);
    t = rd[19:0];
  endtask : now_get

  // load nb bytes, request len bytes at now plus dt
  task automatic send(input logic [15:0] len, input int nb,
      input logic [2:0] lv, input logic [2:0] sc, input logic [19:0] dt,
      input logic [7:0] res);
    apb(1'b1, pds_pkg::REG_CTRL, 32'h4);
    for (int i = 0; i < nb; i++) apb(1'b1, pds_pkg::REG_TXDATA, 32'(i));
    apb(1'b0, pds_pkg::REG_TXDATA, 32'h0);
    check("loaded", rd[6:0], (nb > 64) ? 32'h40 : 32'(nb));
    now_get(t1);
    apb(1'b1, pds_pkg::REG_TXCFG, {9'h000, sc, 1'b0, lv, len});
    apb(1'b1, pds_pkg::REG_TXTIME, {12'h000, t1 + dt});
    line_idx = 8'h00;
    on_cnt = 8'h00;
    apb(1'b1, pds_pkg::REG_CTRL, 32'h1);
    wait_st(pds_pkg::ST_DONE);
    check("result", rd[15:8], res);
    if (res == 8'h00) begin
      check("sent", line_idx, len[7:0]);
      check("level", {line_scheme, line_level}, {sc, lv});
      check("line on", on_cnt, len[7:0]);
      // start sits on a tick edge, so the next tick is far off
      now_get(t2);
      check("start", t2, 20'(t1 + dt));
    end
  endtask : send

  // one received frame through the demodulator side
  task automatic rx(input logic [15:0] n, input logic ok,
      input logic [2:0] sc, input logic [3:0] lv);
    logic good;
    good = ok && sc != 3'h3 && sc != 3'h7;
    now_get(t1);
    dem_preamble <= 1'b1;
    @(posedge pclk);
    dem_preamble <= 1'b0;
    now_get(t2);
    for (int i = 0; i < n; i++) begin
      dem_byte_valid <= 1'b1;
      dem_byte <= 8'hb0 + 8'(i);
      @(posedge pclk);
    end
    dem_byte_valid <= 1'b0;
    dem_end <= 1'b1;
    dem_ok <= ok;
    dem_len <= n;
    dem_level <= lv;
    dem_scheme <= sc;
    @(posedge pclk);
    dem_end <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, pds_pkg::REG_STATUS, 32'h0);
    check("rx flags", rd[4:3], good ? 2'h1 : 2'h2);
    check("rx stored", rd[22:16], good ? n[6:0] : 7'h00);
    apb(1'b1, pds_pkg::REG_STATUS, 32'h18);
    if (good) begin
      apb(1'b0, pds_pkg::REG_RXINFO, 32'h0);
      check("rx info", rd[22:0], {sc, lv, n});
      apb(1'b0, pds_pkg::REG_RXTIME, 32'h0);
      check("stamp", rd[19:0] == t1 || rd[19:0] == t2, 1'b1);
      for (int i = 0; i < n; i++) begin
        apb(1'b0, pds_pkg::REG_RXDATA, 32'h0);
        check("rx byte", rd[7:0], 8'hb0 + 8'(i));
      end
    end
  endtask : rx

  task automatic results;
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // line bytes must leave in loading order
  always @(posedge pclk) begin
    if (line_valid === 1'b1) begin
      check("line byte", line_byte, line_idx);
      line_idx <= line_idx + 8'h01;
    end
    if (line_on === 1'b1) begin
      on_cnt <= on_cnt + 8'h01;
    end
  end

  // hang guard, well beyond the expected 30k cycles
  initial begin
    #400000;
    num_errors++;
    results();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, slot_forbidden, carrier_busy} = 6'h00;
    {dem_preamble, dem_byte_valid, dem_end, dem_ok} = 4'h0;
    {paddr, dem_byte, dem_scheme, dem_level} = 23'h000000;
    pwdata = 32'h0;
    dem_len = 16'h0000;
    line_idx = 8'h00;
    on_cnt = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    now_get(t1);
    check("time", t1, 20'h00000);
    repeat (2500) @(posedge pclk);
    now_get(t2);
    check("time step", t2, 20'h00001);
    // every level and scheme code; codes 3 and 7 refused
    for (int i = 0; i < 8; i++) begin
      send(16'(i + 1), i + 1, 3'(i), 3'(i), 20'h00001,
        (i == 3 || i == 7) ? 8'h03 : 8'h00);
    end
    send(16'h0040, 65, 3'h2, 3'h6, 20'h00001, 8'h00);
    send(16'h0000, 0, 3'h0, 3'h0, 20'h00001, 8'h02);
    send(16'h0041, 1, 3'h0, 3'h0, 20'h00001, 8'h02);
    send(16'h0002, 2, 3'h0, 3'h0, 20'h80010, 8'h01);
    send(16'h0003, 1, 3'h0, 3'h1, 20'h00001, 8'h05);
    slot_forbidden <= 1'b1;
    send(16'h0001, 1, 3'h0, 3'h0, 20'h00001, 8'h07);
    slot_forbidden <= 1'b0;
    carrier_busy <= 1'b1;
    send(16'h0001, 1, 3'h0, 3'h0, 20'h00001, 8'h06);
    carrier_busy <= 1'b0;
    // unmapped place gives an error and zero data
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    // a failed frame empties the store before each good one
    for (int s = 0; s < 8; s++) begin
      rx(16'h0001, 1'b0, 3'h0, 4'h0);
      rx(16'(s + 1), 1'b1, 3'(s), 4'(2 * s + 1));
    end
    results();
  end
endmodule : tb_top
